// [apsh_defines.svh]
`ifndef APSH_DEFINES_SVH
`define APSH_DEFINES_SVH
// register byte offsets
`define APSH_BUS_CTRL_OFS   8'h00
`define APSH_PA_PUR_OFS     8'h04
`define APSH_PE_PUR_OFS     8'h08
`define APSH_PB_FSEL_OFS    8'h0c
`define APSH_PA_DIR_OFS     8'h10
`define APSH_PA_DOUT_OFS    8'h14
`define APSH_PE_DIR_OFS     8'h18
`define APSH_PE_DOUT_OFS    8'h1c
`define APSH_PB_DIR_OFS     8'h20
`define APSH_PB_DOUT_OFS    8'h24
`define APSH_PIN_IN_OFS     8'h28
`define APSH_PB_PUR_OFS     8'h2c
`define APSH_PA_FSEL_OFS    8'h30
`define APSH_PE_FSEL_OFS    8'h34
// field positions
`define APSH_DRV_BIT        0
// reset values
`define APSH_BUS_CTRL_RST   1'h0
`define APSH_PA_PUR_RST     8'hff
`define APSH_PE_PUR_RST     2'h3
`define APSH_PB_PUR_RST     4'hf
// function selects: 1 = port, reset leaves ports A and E in the address function
`define APSH_PA_FSEL_RST    8'h00
`define APSH_PE_FSEL_RST    2'h0
`define APSH_PB_FSEL_MASK   4'hf
`endif

// [apsh_pkg.sv]
package apsh_pkg;
  // one pin group bundle: 14 shared pins, index 0..13 = A6..A19
  typedef struct packed {
    logic [13:0] val;
  } apsh_pins_t;
  // wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } apsh_wb_req_t;
endpackage

// [apsh_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "apsh_defines.svh"
module apsh_top (
  input  wire logic                  clk_i,       // 20 MHz system clock
  input  wire logic                  rst_i,       // sync reset, active high
  input  wire apsh_pkg::apsh_wb_req_t wb_req_i,   // wishbone request
  output logic [31:0]                wb_dat_o,    // wishbone read data
  output logic                       wb_ack_o,    // wishbone acknowledge
  input  wire logic [19:6]           emi_addr_i,  // memory interface address
  input  wire logic                  emi_active_i,// external bus cycle in progress
  input  wire logic                  boot_ext_i,  // external_boot_strap
  input  wire logic                  memory_interface_mode_strap_i,  // memory_interface_mode_strap
  input  wire logic                  flash_sec_i, // flash security setting
  input  wire apsh_pkg::apsh_pins_t  pin_i,      // pad input levels
  output apsh_pkg::apsh_pins_t       pin_o,       // pad output levels
  output apsh_pkg::apsh_pins_t       pin_oe_o,    // pad output enables
  output apsh_pkg::apsh_pins_t       pin_pu_o     // pad pull-up enables
);
  import apsh_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // control registers
  logic        drive_hold;      // drive_hold_bit of bus_control_register
  logic [7:0]  pa_pullup;       // port_a_pullup_register, A8..A15
  logic [1:0]  pe_pullup;       // port_e_pullup_register bits 3:2 -> A6,A7
  logic [3:0]  pb_pullup;       // port b pull-ups, A16..A19
  logic [3:0]  pb_fsel;         // port_b_function_select, 1 = port
  logic [7:0]  pa_fsel;         // port a function select, 1 = port
  logic [1:0]  pe_fsel;         // port e function select, 1 = port
  logic [7:0]  pa_dir, pa_dout; // port a direction / data
  logic [1:0]  pe_dir, pe_dout; // port e pins 2,3
  logic [3:0]  pb_dir, pb_dout; // port b pins 0..3
  logic        strap_done;      // straps sampled after reset
  logic        wr_hit;          // write strobe this cycle
  logic [13:0] addr_mode;       // 1 = pin in address function
  logic [13:0] port_dir;        // flat direction, A6..A19
  logic [13:0] port_dout;       // flat output data
  logic [13:0] port_pu;         // flat pull-up enables
  logic [19:6] addr_mux;        // flat address, index aligned

  assign wr_hit = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~wb_ack_o & wb_req_i.sel[0];

  ////////////////////////////////////////////////////////////////////
  // bus control and pull-up registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_hold <= `APSH_BUS_CTRL_RST;
      pa_pullup  <= `APSH_PA_PUR_RST;
      pe_pullup  <= `APSH_PE_PUR_RST;
      pb_pullup  <= `APSH_PB_PUR_RST;
    end else if (wr_hit) begin
      unique case (wb_req_i.adr)
        `APSH_BUS_CTRL_OFS: drive_hold <= wb_req_i.dat[`APSH_DRV_BIT];
        `APSH_PA_PUR_OFS:   pa_pullup  <= wb_req_i.dat[7:0];
        `APSH_PE_PUR_OFS:   pe_pullup  <= wb_req_i.dat[3:2];
        `APSH_PB_PUR_OFS:   pb_pullup  <= wb_req_i.dat[3:0];
        default:            pb_pullup  <= pb_pullup;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // port b function select: strap choice then software override
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pb_fsel    <= `APSH_PB_FSEL_MASK;  // port until straps caught
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      // address only when booting externally in wide mode, unsecured
      pb_fsel    <= (boot_ext_i & memory_interface_mode_strap_i & ~flash_sec_i) ? 4'h0 : `APSH_PB_FSEL_MASK;
    end else if (wr_hit && wb_req_i.adr == `APSH_PB_FSEL_OFS) begin
      pb_fsel    <= wb_req_i.dat[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // port a and e function select, address after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_fsel <= `APSH_PA_FSEL_RST;
      pe_fsel <= `APSH_PE_FSEL_RST;
    end else if (wr_hit && wb_req_i.adr == `APSH_PA_FSEL_OFS) begin
      pa_fsel <= wb_req_i.dat[7:0];  // per pin, not per port
    end else if (wr_hit && wb_req_i.adr == `APSH_PE_FSEL_OFS) begin
      pe_fsel <= wb_req_i.dat[3:2];  // port e pins 2,3
    end
  end

  ////////////////////////////////////////////////////////////////////
  // port direction and data registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_dir <= 8'h00; pa_dout <= 8'h00;
      pe_dir <= 2'h0;  pe_dout <= 2'h0;
      pb_dir <= 4'h0;  pb_dout <= 4'h0;
    end else if (wr_hit) begin
      unique case (wb_req_i.adr)
        `APSH_PA_DIR_OFS:  pa_dir  <= wb_req_i.dat[7:0];
        `APSH_PA_DOUT_OFS: pa_dout <= wb_req_i.dat[7:0];
        `APSH_PE_DIR_OFS:  pe_dir  <= wb_req_i.dat[3:2];
        `APSH_PE_DOUT_OFS: pe_dout <= wb_req_i.dat[3:2];
        `APSH_PB_DIR_OFS:  pb_dir  <= wb_req_i.dat[3:0];
        `APSH_PB_DOUT_OFS: pb_dout <= wb_req_i.dat[3:0];
        default:           pa_dir  <= pa_dir;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flatten per-pin controls, index 0 = A6
  assign addr_mode = ~{pb_fsel, pa_fsel, pe_fsel};
  assign port_dir  = {pb_dir, pa_dir, pe_dir};
  assign port_dout = {pb_dout, pa_dout, pe_dout};
  assign port_pu   = {pb_pullup, pa_pullup, pe_pullup};
  assign addr_mux  = emi_addr_i;

  ////////////////////////////////////////////////////////////////////
  // per-pin output mux, registered
  genvar g;
  generate
    for (g = 0; g < 14; g++) begin : g_pin
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pin_o.val[g]    <= 1'b0;
          pin_oe_o.val[g] <= 1'b0;  // tri-stated during reset
          pin_pu_o.val[g] <= 1'b1;
        end else if (addr_mode[g]) begin
          pin_o.val[g]    <= addr_mux[g+6];
          pin_oe_o.val[g] <= emi_active_i | drive_hold;
          pin_pu_o.val[g] <= port_pu[g];
        end else begin
          pin_o.val[g]    <= port_dout[g];
          pin_oe_o.val[g] <= port_dir[g];
          pin_pu_o.val[g] <= port_pu[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // wishbone read data and ack, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
      unique case (wb_req_i.adr)
        `APSH_BUS_CTRL_OFS: wb_dat_o <= {31'h0, drive_hold};
        `APSH_PA_PUR_OFS:   wb_dat_o <= {24'h0, pa_pullup};
        `APSH_PE_PUR_OFS:   wb_dat_o <= {28'h0, pe_pullup, 2'h0};
        `APSH_PB_FSEL_OFS:  wb_dat_o <= {28'h0, pb_fsel};
        `APSH_PA_DIR_OFS:   wb_dat_o <= {24'h0, pa_dir};
        `APSH_PA_DOUT_OFS:  wb_dat_o <= {24'h0, pa_dout};
        `APSH_PE_DIR_OFS:   wb_dat_o <= {28'h0, pe_dir, 2'h0};
        `APSH_PE_DOUT_OFS:  wb_dat_o <= {28'h0, pe_dout, 2'h0};
        `APSH_PB_DIR_OFS:   wb_dat_o <= {28'h0, pb_dir};
        `APSH_PB_DOUT_OFS:  wb_dat_o <= {28'h0, pb_dout};
        `APSH_PIN_IN_OFS:   wb_dat_o <= {18'h0, pin_i.val};
        `APSH_PB_PUR_OFS:   wb_dat_o <= {28'h0, pb_pullup};
        `APSH_PA_FSEL_OFS:  wb_dat_o <= {24'h0, pa_fsel};
        `APSH_PE_FSEL_OFS:  wb_dat_o <= {28'h0, pe_fsel, 2'h0};
        default:            wb_dat_o <= 32'h0;  // unmapped reads zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  hold_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (drive_hold && addr_mode[0]) |=> pin_oe_o.val[0])
    else $error("address pin not held driven");
  idle_tri_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!drive_hold && !emi_active_i && addr_mode[2]) |=> !pin_oe_o.val[2])
    else $error("idle address pin not tri-stated");
  addr_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    addr_mode[5] |=> pin_o.val[5] == $past(emi_addr_i[11]))
    else $error("address bit not on pin");
  port_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !addr_mode[13] |=> pin_oe_o.val[13] == $past(pb_dir[3]))
    else $error("port direction not followed");
  port_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !addr_mode[10] |=> pin_o.val[10] == $past(pb_dout[0]))
    else $error("port data not followed");
  low_addr_a: assert property (@(posedge clk_i)
    rst_i |=> addr_mode[9:0] == 10'h3ff)
    else $error("low pins not address after reset");
  pullup_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 pin_pu_o.val[4] == $past(pa_pullup[2]))
    else $error("pull-up bit misplaced");
  fsel_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (strap_done && wr_hit && wb_req_i.adr == `APSH_PB_FSEL_OFS)
      |=> pb_fsel == $past(wb_req_i.dat[3:0]))
    else $error("function select write lost");
  strap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!strap_done) |=> pb_fsel == (($past(boot_ext_i & memory_interface_mode_strap_i & ~flash_sec_i)) ? 4'h0 : 4'hf))
    else $error("strap choice wrong");
  pu_reset_a: assert property (@(posedge clk_i)
    rst_i |=> (pin_pu_o.val == 14'h3fff))
    else $error("pull-ups not on after reset");
  pa_gpio_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !addr_mode[2] |=> pin_oe_o.val[2] == $past(pa_dir[0]))
    else $error("port a direction not followed");
  pa_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !addr_mode[2] |=> pin_o.val[2] == $past(pa_dout[0]))
    else $error("port a data not followed");
  pe_pull_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 pin_pu_o.val[1:0] == $past(pe_pullup))
    else $error("port e pull-ups misplaced");
  pb_pull_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 pin_pu_o.val[13:10] == $past(pb_pullup))
    else $error("port b pull-ups misplaced");
endmodule // apsh_top
`default_nettype wire

// [apsh_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
// far side: external memory and board, resolving each pad level
module apsh_mem_model
  import apsh_pkg::*;
(
  input  wire logic       clk_i, // system clock
  input  wire apsh_pins_t o_i,   // device pad data
  input  wire apsh_pins_t oe_i,  // device pad enables
  input  wire apsh_pins_t pu_i,  // device pull-ups
  output apsh_pins_t      pad_o  // level seen on each pad
);
  import apsh_pkg::*;
  logic [13:0] flip = 14'h0; // level of a floating pad, never steady
  // floating pads toggle so a stale value never passes
  always @(posedge clk_i) begin
    flip <= ~flip;
  end
  // driven pads follow the device, released ones go to pull-up or float
  always_comb begin
    pad_o.val = (oe_i.val & o_i.val) | (~oe_i.val & (pu_i.val | flip));
  end
endmodule // apsh_mem_model
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import apsh_pkg::*;
  logic         clk, rst, act;      // clock, reset, bus active
  logic         boot, mode, sec;    // strap levels
  apsh_wb_req_t req;                // bus request
  logic [31:0]  dat;                // read data
  logic         ack;                // acknowledge
  logic [19:6]  addr;               // memory address
  apsh_pins_t   pad, po, poe, ppu;  // pad level, data, enable, pull-up
  int           miscompares, checked; // counters
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  apsh_top DUT (.clk_i(clk), .rst_i(rst), .wb_req_i(req), .wb_dat_o(dat), .wb_ack_o(ack),
    .emi_addr_i(addr), .emi_active_i(act), .boot_ext_i(boot), .memory_interface_mode_strap_i(mode),
    .flash_sec_i(sec), .pin_i(pad), .pin_o(po), .pin_oe_o(poe), .pin_pu_o(ppu));
  apsh_mem_model mem (.clk_i(clk), .o_i(po), .oe_i(poe), .pu_i(ppu), .pad_o(pad));
  ////////////////////////////////////////////////////////////////
  // compare one value
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  // closing report
  task automatic test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one classic wishbone cycle, read data taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, 4'hf, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = dat;
    req <= '0;
    if (n >= 20) begin
      miscompares++;
      test_done;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  // let pad outputs settle, then look at them
  task automatic settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  // straps 1,1,0 give port B the address function
  task automatic t_reset;
    rd(8'h0c, 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'hff);
    rd(8'h08, 32'hc);
    rd(8'h3c, 32'h0);
    rd(8'h2c, 32'hf);
    rd(8'h30, 32'h0);
    rd(8'h34, 32'h0);
  endtask
  // address drive while active, released when idle, held by drive-hold
  task automatic t_addr;
    @(posedge clk);
    act <= 1'b1;
    addr <= 14'h2a5c;
    settle;
    chk(pad.val, 14'h2a5c);
    chk(poe.val, 14'h3fff);
    @(posedge clk);
    act <= 1'b0;
    settle;
    chk(poe.val, 14'h0);
    wr(8'h00, 32'h1);
    settle;
    chk(poe.val, 14'h3fff);
  endtask
  // port B as gpio, alternate pins out, others in with pull-up
  task automatic t_port;
    wr(8'h0c, 32'hf);
    wr(8'h20, 32'h5);
    wr(8'h24, 32'h5);
    settle;
    chk(poe.val, 14'h17ff);
    chk(po.val[13:10] & 4'h5, 4'h5);
    rd(8'h28, 32'h3e5c);
    wr(8'h0c, 32'h0);
    settle;
    chk(poe.val, 14'h3fff);
  endtask
  // pull-up bit n switches pin n of its port
  task automatic t_pull;
    wr(8'h04, 32'hfb);
    wr(8'h08, 32'h4);
    settle;
    chk(ppu.val, 14'h3fed);
    rd(8'h04, 32'hfb);
    wr(8'h2c, 32'h7);
    settle;
    chk(ppu.val, 14'h1fed);
    rd(8'h2c, 32'h7);
  endtask
  // port a pin 0 and port e pin 3 handed to the port, then back
  task automatic t_gpio;
    wr(8'h08, 32'hc);
    wr(8'h30, 32'h1);
    wr(8'h34, 32'h8);
    wr(8'h10, 32'h1);
    wr(8'h1c, 32'h8);
    settle;
    chk(poe.val, 14'h3ffd);
    chk(po.val[2], 1'b0);
    rd(8'h28, 32'h2a5a);
    wr(8'h18, 32'h8);
    settle;
    chk(poe.val, 14'h3fff);
    chk(po.val[1], 1'b1);
    wr(8'h30, 32'h0);
    wr(8'h34, 32'h0);
    settle;
    chk(po.val, 14'h2a5c);
  endtask
  // mid-run reset with flash secured: port B comes up as port
  task automatic t_strap;
    @(posedge clk);
    rst <= 1'b1;
    sec <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(poe.val, 14'h0);
    chk(ppu.val, 14'h3fff);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(poe.val, 14'h0);
    rd(8'h0c, 32'hf);
    rd(8'h04, 32'hff);
    rd(8'h30, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    miscompares = 0;
    checked = 0;
    rst = 1'b1;
    act = 1'b0;
    boot = 1'b1;
    mode = 1'b1;
    sec = 1'b0;
    addr = 14'h0;
    req = '0;
    repeat (19) @(posedge clk);
    @(negedge clk);
    chk(poe.val, 14'h0);
    chk(ppu.val, 14'h3fff);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_addr;
    t_port;
    t_pull;
    t_gpio;
    t_strap;
    test_done;
  end
  // hang guard
  initial begin
    #2000000;
    miscompares++;
    test_done;
  end
endmodule // tb
`default_nettype wire
